// File: inc/lgs_pkg.sv
// Function
// [R1] Bits 7:4 of source register pick remote pin data; bit 4+n is pin n
// [R2] Forward enable bits reset to all ones, pins default to remote data
// [R3] Bits 3:0 of source register hold local drive level; reset zero
// [R4] Local level drives pin only when forward clear and output enabled
// [R5] Direction bits 7:4 enable output drivers per pin; reset zero
// [R6] Direction bits 3:0 enable input buffers per pin; reset one
// [R7] Forward and output enable both set drive latest remote pin state
package lgs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SRC_ADDR = 8'h0d;
  localparam logic [7:0] DIR_ADDR = 8'h0e;
  localparam logic [7:0] SRC_RST = 8'hf0;
  localparam logic [7:0] DIR_RST = 8'h0f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PIN_CNT = 4;
  localparam int FWD_LSB = 4;
  localparam int DRV_LSB = 0;
  localparam int OE_LSB = 4;
  localparam int IE_LSB = 0;

endpackage

// File: rtl/lgs_pin_cell.sv
`timescale 1ns/1ns
module lgs_pin_cell (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Per-pin configuration
  input wire logic fwd_en_i,
  input wire logic drv_val_i,
  input wire logic out_en_i,
  input wire logic in_en_i,
  // Remote pin state from the back channel
  input wire logic remote_val_i,
  // Pad signals
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_n_o,
  // Sampled pad level for the device
  output logic pad_in_o
);

  // ****************************************
  // Output path
  // ****************************************
  logic out_q, out_d;
  logic oe_n_q, oe_n_d;

  always_comb begin
    out_d = fwd_en_i ? remote_val_i : drv_val_i; // [R1] [R4] [R7]
    oe_n_d = ~out_en_i; // [R4] [R5] [R7]
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ****************************************
  // Input path
  // ****************************************
  logic sync1_q, sync2_q, in_q, in_d;

  always_comb begin
    in_d = in_en_i ? sync2_q : 1'b0; // [R6]
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      in_q <= 1'b0;
    end else begin
      sync1_q <= pad_i;
      sync2_q <= sync1_q;
      in_q <= in_d;
    end
  end

  assign pad_o = out_q;
  assign pad_oe_n_o = oe_n_q;
  assign pad_in_o = in_q;

endmodule

// File: rtl/lgs_gpio_ctrl.sv
`timescale 1ns/1ns
module lgs_gpio_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Remote pin states from the back channel
  input wire logic [3:0] remote_pin_i,
  // Pads
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_n_o,
  // Sampled pad levels
  output logic [3:0] pin_in_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] src_q, src_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_src, wr_dir;

  always_comb begin
    wr_src = reg_wr_i && (reg_addr_i == lgs_pkg::SRC_ADDR);
    wr_dir = reg_wr_i && (reg_addr_i == lgs_pkg::DIR_ADDR);
    src_d = src_q;
    dir_d = dir_q;
    rdata_d = rdata_q;
    if (wr_src) begin
      src_d = reg_wdata_i; // [R1] [R3]
    end
    if (wr_dir) begin
      dir_d = reg_wdata_i; // [R5] [R6]
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        lgs_pkg::SRC_ADDR: rdata_d = src_q;
        lgs_pkg::DIR_ADDR: rdata_d = dir_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_q <= lgs_pkg::SRC_RST; // [R2] [R3]
      dir_q <= lgs_pkg::DIR_RST; // [R5] [R6]
      rdata_q <= 8'h00;
    end else begin
      src_q <= src_d;
      dir_q <= dir_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ****************************************
  // Pin cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < lgs_pkg::PIN_CNT; gi++) begin : g_pin
      lgs_pin_cell u_cell (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .fwd_en_i(src_q[lgs_pkg::FWD_LSB + gi]), // [R1]
        .drv_val_i(src_q[lgs_pkg::DRV_LSB + gi]), // [R3]
        .out_en_i(dir_q[lgs_pkg::OE_LSB + gi]), // [R5]
        .in_en_i(dir_q[lgs_pkg::IE_LSB + gi]), // [R6]
        .remote_val_i(remote_pin_i[gi]),
        .pad_i(pin_i[gi]),
        .pad_o(pin_o[gi]),
        .pad_oe_n_o(pin_oe_n_o[gi]),
        .pad_in_o(pin_in_o[gi])
      );

      // ****************************************
      // Per-pin checks
      // ****************************************
      property p_fwd_drive;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        src_q[lgs_pkg::FWD_LSB + gi] && dir_q[lgs_pkg::OE_LSB + gi]
        |=> pin_o[gi] == $past(remote_pin_i[gi]) && !pin_oe_n_o[gi];
      endproperty
      a_fwd_drive: assert property (p_fwd_drive) // [R7]
        else $error("Forwarded pin does not carry remote state");

      property p_local_drive;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !src_q[lgs_pkg::FWD_LSB + gi] && dir_q[lgs_pkg::OE_LSB + gi]
        |=> pin_o[gi] == $past(src_q[lgs_pkg::DRV_LSB + gi]);
      endproperty
      a_local_drive: assert property (p_local_drive) // [R4]
        else $error("Local pin does not carry written level");

      property p_fwd_select;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        src_q[lgs_pkg::FWD_LSB + gi] && !remote_pin_i[gi]
        |=> !pin_o[gi];
      endproperty
      a_fwd_select: assert property (p_fwd_select) // [R1]
        else $error("Forward enable ignored on pin");

      property p_out_enable;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        1'b1 |=> pin_oe_n_o[gi] == !$past(dir_q[lgs_pkg::OE_LSB + gi]);
      endproperty
      a_out_enable: assert property (p_out_enable) // [R5]
        else $error("Pin driver enable mismatch");

      sequence s_in_off;
        !dir_q[lgs_pkg::IE_LSB + gi];
      endsequence

      property p_in_gate;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_in_off |=> !pin_in_o[gi];
      endproperty
      a_in_gate: assert property (p_in_gate) // [R6]
        else $error("Disabled input buffer passes pad level");

      sequence s_in_on;
        !sys_rst_i ##1 dir_q[lgs_pkg::IE_LSB + gi] [*3];
      endsequence

      property p_in_pass;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_in_on |-> pin_in_o[gi] == $past(pin_i[gi], 3);
      endproperty
      a_in_pass: assert property (p_in_pass) // [R6]
        else $error("Enabled input does not follow pad");

      property p_undriven;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !dir_q[lgs_pkg::OE_LSB + gi] |=> pin_oe_n_o[gi];
      endproperty
      a_undriven: assert property (p_undriven) // [R5]
        else $error("Pin driven with output enable cleared");

      property p_local_blocked;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        src_q[lgs_pkg::FWD_LSB + gi]
        |=> pin_o[gi] == $past(remote_pin_i[gi]);
      endproperty
      a_local_blocked: assert property (p_local_blocked) // [R4]
        else $error("Local level reaches a forwarded pin");
    end
  endgenerate

  // ****************************************
  // Register checks
  // ****************************************
  property p_src_reset;
    @(posedge clk_sys_i)
    $fell(sys_rst_i) |-> src_q == lgs_pkg::SRC_RST;
  endproperty
  a_src_reset: assert property (p_src_reset) // [R2]
    else $error("Source register reset value wrong");

  property p_drv_reset;
    @(posedge clk_sys_i)
    $fell(sys_rst_i) |-> src_q[3:0] == 4'h0 && pin_oe_n_o == 4'hf;
  endproperty
  a_drv_reset: assert property (p_drv_reset) // [R3]
    else $error("Drive level or driver not idle after reset");

  property p_dir_reset;
    @(posedge clk_sys_i)
    $fell(sys_rst_i) |-> dir_q == lgs_pkg::DIR_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset) // [R5]
    else $error("Direction register reset value wrong");

  sequence s_src_write;
    reg_wr_i && reg_addr_i == lgs_pkg::SRC_ADDR;
  endsequence

  sequence s_src_read;
    reg_rd_i && reg_addr_i == lgs_pkg::SRC_ADDR && !reg_wr_i;
  endsequence

  property p_src_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_src_write ##1 s_src_read |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_src_write: assert property (p_src_write) // [R1]
    else $error("Source register readback mismatch");

  property p_dir_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == lgs_pkg::DIR_ADDR
    |=> dir_q == $past(reg_wdata_i);
  endproperty
  a_dir_write: assert property (p_dir_write) // [R6]
    else $error("Direction register write lost");

  property p_src_update;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_src_write |=> src_q == $past(reg_wdata_i);
  endproperty
  a_src_update: assert property (p_src_update) // [R3]
    else $error("Source register write lost");

  property p_src_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !(reg_wr_i && reg_addr_i == lgs_pkg::SRC_ADDR)
    |=> $stable(src_q);
  endproperty
  a_src_hold: assert property (p_src_hold) // [R1]
    else $error("Source register changed without write");

  property p_dir_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !(reg_wr_i && reg_addr_i == lgs_pkg::DIR_ADDR)
    |=> $stable(dir_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold) // [R5]
    else $error("Direction register changed without write");

  property p_dir_read;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == lgs_pkg::DIR_ADDR
    |=> reg_rdata_o == $past(dir_q);
  endproperty
  a_dir_read: assert property (p_dir_read) // [R6]
    else $error("Direction register readback mismatch");

endmodule

// File: tb/lgs_remote_model.sv
`timescale 1ns/1ns
module lgs_remote_model (
  // Clock
  input wire logic clk_sys_i,
  // Pin states the far side should send
  input wire logic [3:0] state_i,
  // Pin states delivered over the back channel
  output logic [3:0] remote_pin_o
);
  // ****************************************
  // Back channel, one state update per clock
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    remote_pin_o <= state_i;
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst;
  logic [7:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic rd;
  logic [7:0] rdata;
  logic [3:0] rstate;
  logic [3:0] remote;
  logic [3:0] ext;
  logic [3:0] pad;
  logic [3:0] pin_o;
  logic [3:0] oe_n;
  logic [3:0] pin_in;
  int err_count = 0;
  int num_checks = 0;

  // Pad level: design when driving, outside level otherwise
  assign pad = (oe_n & ext) | (~oe_n & pin_o);

  initial begin
    forever #25 clk = ~clk;
  end

  lgs_remote_model i_lgs_remote_model (
    .clk_sys_i(clk),
    .state_i(rstate),
    .remote_pin_o(remote)
  );

  lgs_gpio_ctrl i_lgs_gpio_ctrl (
    .clk_sys_i(clk),
    .sys_rst_i(rst),
    .reg_addr_i(addr),
    .reg_wr_i(wr),
    .reg_wdata_i(wdata),
    .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .remote_pin_i(remote),
    .pin_i(pad),
    .pin_o(pin_o),
    .pin_oe_n_o(oe_n),
    .pin_in_o(pin_in)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdata, exp);
  endtask

  task automatic reg_wr_rd(input logic [7:0] a, input logic [7:0] d,
                           input logic [7:0] exp);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdata, exp);
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    rstate = 4'ha;
    ext = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_pin(oe_n, 4'hf);
    reg_read(lgs_pkg::SRC_ADDR, 8'hf0);
    reg_read(lgs_pkg::DIR_ADDR, 8'h0f);
    reg_read(8'h0b, 8'h00);
    reg_write(8'h0b, 8'h55);
    reg_read(lgs_pkg::SRC_ADDR, 8'hf0);
    reg_write(lgs_pkg::DIR_ADDR, 8'hff);
    settle();
    chk_pin(pin_o, 4'ha);
    chk_pin(oe_n, 4'h0);
    reg_write(lgs_pkg::SRC_ADDR, 8'h35);
    settle();
    chk_pin(pin_o, 4'h6);
    @(posedge clk);
    rstate <= 4'h3;
    settle();
    chk_pin(pin_o, 4'h7);
    reg_write(lgs_pkg::DIR_ADDR, 8'h3f);
    settle();
    chk_pin(oe_n, 4'hc);
    @(posedge clk);
    ext <= 4'h4;
    settle();
    chk_pin(pin_in, 4'h7);
    reg_write(lgs_pkg::DIR_ADDR, 8'h35);
    settle();
    chk_pin(pin_in, 4'h5);
    reg_read(lgs_pkg::DIR_ADDR, 8'h35);
    reg_read(lgs_pkg::SRC_ADDR, 8'h35);
    reg_wr_rd(lgs_pkg::SRC_ADDR, 8'hc9, 8'hc9);
    settle();
    chk_pin(pin_o, 4'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_pin(oe_n, 4'hf);
    reg_read(lgs_pkg::SRC_ADDR, 8'hf0);
    reg_read(lgs_pkg::DIR_ADDR, 8'h0f);
    settle();
    chk_pin(pin_in, 4'h4);
    conclude();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
